// >>> verilog/hdog_pkg.sv
package hdog_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_PWR   = 8'h05;
    localparam logic [7:0] IDX_FAULT = 8'h1D;
    localparam logic [7:0] IDX_CFGA  = 8'h20;
    localparam logic [7:0] IDX_CFGB  = 8'h21;
    localparam logic [7:0] IDX_JACK  = 8'h22;
    localparam logic [7:0] IDX_POP   = 8'h25;
    // power register: a 1 powers the driver down
    localparam int B_SPK_PD = 12;
    localparam int B_EAR_PD = 11;
    localparam int B_MB_PD  = 9;
    localparam int B_VG_PD  = 8;
    localparam int B_HPL_PD = 7;
    localparam int B_HPR_PD = 6;
    localparam logic [15:0] RST_PWR = 16'h1BC0;
    localparam logic [15:0] MSK_PWR = 16'h1BC0;
    // fault register
    localparam int B_FAULT  = 1;
    localparam int B_SWRST  = 15;
    // configuration registers
    localparam int B_SC_DIS    = 0;
    localparam int B_VG_SC_DIS = 4;
    localparam int B_SPK_SC_EN = 5;
    localparam logic [15:0] MSK_CFGA = 16'h0001;
    localparam logic [15:0] MSK_CFGB = 16'h0030;
    // jack register
    localparam int B_DET_EN  = 15;
    localparam int B_HS_PRES = 12;
    localparam int B_BTN     = 11;
    localparam int B_HS_DB   = 9;
    localparam int B_BT_DB   = 5;
    localparam int B_GP2_EN  = 4;
    localparam int B_GP1_EN  = 3;
    localparam int B_BT_INT  = 0;
    localparam logic [15:0] MSK_JACK = 16'h867B;
    // pop / routing register
    localparam int B_PD_STAT  = 10;
    localparam int B_RT_LEFT  = 7;
    localparam int B_RT_RIGHT = 6;
    localparam int B_POP_DIS  = 5;
    localparam int B_RAMP_LNG = 4;
    localparam logic [15:0] MSK_POP = 16'h00F0;
    localparam logic [15:0] RST_ZERO = 16'h0000;
    // timing: quarter-millisecond base tick at 20 MHz
    localparam int CLK_KHZ      = 20000;
    localparam int QTICK_US     = 250;
    localparam int QTICK_CYC    = CLK_KHZ * QTICK_US / 1000;
    localparam int POP_FAST_US  = 1000;
    localparam int POP_SLOW_US  = 800000;
    localparam int POP_LONG_US  = 4000000;
    localparam int HS_PULSE_US  = 1750;
    localparam int BT_DELAY_US  = 500;
    localparam logic [13:0] POP_FAST_Q = 14'(POP_FAST_US / QTICK_US);
    localparam logic [13:0] POP_SLOW_Q = 14'(POP_SLOW_US / QTICK_US);
    localparam logic [13:0] POP_LONG_Q = 14'(POP_LONG_US / QTICK_US);
    localparam logic [2:0]  HS_PULSE_Q = 3'(HS_PULSE_US / QTICK_US);
    localparam logic [1:0]  BT_DELAY_Q = 2'(BT_DELAY_US / QTICK_US);
    localparam logic [2:0]  DB_TICKS   = 3'h7;
endpackage

// >>> verilog/hdog_guard.sv
// Function
// RQ1: short circuit latches fault, drivers off
// RQ2: hard or soft reset clears fault
// RQ3: host powers drivers down, waits status
// RQ4: configuration bit disables short protection
// RQ5: separate bit disables virtual ground protection
// RQ6: pop reduction on after reset, disable bit
// RQ7: capacitor ramp of 0.8 s or 4 s
// RQ8: virtual ground in use gives 1 ms
// RQ9: pop sequence on every headphone power-up; the code starts it only when the first one powers up
// RQ10: speaker short protection enable bit
// RQ11: earpiece and headphones never on together
// RQ12: two bits route headphones to buzzer stage
// RQ13: detection works only while enabled
// RQ14: headset present flag follows insertion, removal
// RQ15: per-pin enables for insertion interrupt
// RQ16: no headset forces right, ground, bias off
// RQ17: button flag and two-bit interrupt control
// RQ18: headset debounce 16 to 128 ms
// RQ19: insertion interrupt pulse 1.75 ms
// RQ20: present flag stays while headset connected
// RQ21: button debounce none or 8 to 32 ms
// RQ22: button interrupt delay and hold time
// RQ23: button flag clears on read after release
// RQ24: debounce counts ticks of stable input
//
// Register access over APB and the address map were left to the implementer.
module hdog_guard
    import hdog_pkg::*;
#(
    parameter int QT_CYC = QTICK_CYC
) (
    // apb
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [9:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // sense pins
    input  wire logic        jack_sense_input,
    input  wire logic        button_sense,
    input  wire logic        hp_short,
    input  wire logic        virtual_ground_amp_short,
    input  wire logic        spk_short,
    // driver controls
    output logic             headphone_left_out,
    output logic             headphone_right_out,
    output logic             virtual_ground_amp,
    output logic             loudspeaker_diff_out,
    output logic             earpiece_diff_out,
    output logic             headset_mic_bias,
    output logic             pop_ramp_active,
    output logic             route_left_buzzer,
    output logic             route_right_buzzer,
    // interrupts
    output logic             gp_pin_one,
    output logic             gp_pin_two
);
    logic [15:0] r_pwr, r_cfga, r_cfgb, r_jack, r_pop;
    logic [4:0]  s1, s2;
    logic        fault, soft_rst;
    logic        hpl, hpr, vg, spk, ear, mb;
    logic        hs_state, hs_force, hp_prev;
    logic [2:0]  hs_cnt, hs_pcnt, bt_cnt;
    logic        bt_state, bt_irq, bt_flag;
    logic [1:0]  bt_dcnt;
    logic        bt_wait;
    logic [13:0] pop_cnt;
    logic [15:0] qdiv;
    logic        qtick;
    logic [5:0]  qcnt;

    function automatic logic tick_at(input logic [5:0] q, input logic [2:0] sh);
        logic [5:0] m;
        m = (6'h01 << sh) - 6'h01;
        return (q & m) == 6'h00;
    endfunction

    wire [7:0] idx    = paddr[9:2];
    wire       jk_s   = s2[4];
    wire       bt_s   = s2[3];
    wire       hps_s  = s2[2];
    wire       vgs_s  = s2[1];
    wire       sps_s  = s2[0];
    wire       wr     = psel & penable & pwrite;
    wire       rd_jk  = psel & penable & ~pwrite & (idx == IDX_JACK);
    wire       det_en = r_jack[B_DET_EN];
    wire [5:0] stat   = {~hpl, ~hpr, ~vg, ~spk, ~ear, ~mb};

    // pins cross in through two flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1 <= 5'h00;
            s2 <= 5'h00;
        end else begin
            s1 <= {jack_sense_input, button_sense, hp_short, virtual_ground_amp_short, spk_short};
            s2 <= s1;
        end
    end

    // apb: zero wait; read data and error sampled in the setup cycle
    function automatic logic [15:0] rd_val(input logic [7:0] i);
        unique case (i)
            IDX_PWR:   rd_val = r_pwr;
            IDX_FAULT: rd_val = 16'(fault) << B_FAULT;
            IDX_CFGA:  rd_val = r_cfga;
            IDX_CFGB:  rd_val = r_cfgb;
            IDX_JACK:  rd_val = r_jack | (16'(hs_state) << B_HS_PRES)
                                       | (16'(bt_flag) << B_BTN);
            IDX_POP:   rd_val = r_pop | (16'(stat) << B_PD_STAT);
            default:   rd_val = 16'h0000;
        endcase
    endfunction

    function automatic logic mapped(input logic [7:0] i);
        return i == IDX_PWR || i == IDX_FAULT || i == IDX_CFGA
            || i == IDX_CFGB || i == IDX_JACK || i == IDX_POP;
    endfunction

    assign pready = 1'b1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata  <= {16'h0000, rd_val(idx)};
            pslverr <= !mapped(idx);
        end
    end

    // control registers; a software reset restores them too
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_pwr    <= RST_PWR;
            r_cfga   <= RST_ZERO;
            r_cfgb   <= RST_ZERO;
            r_jack   <= RST_ZERO;
            r_pop    <= RST_ZERO; // RQ6
            soft_rst <= 1'b0;
        end else if (soft_rst) begin
            r_pwr    <= RST_PWR; // RQ2
            r_cfga   <= RST_ZERO;
            r_cfgb   <= RST_ZERO;
            r_jack   <= RST_ZERO;
            r_pop    <= RST_ZERO;
            soft_rst <= 1'b0;
        end else begin
            soft_rst <= wr && idx == IDX_FAULT && pwdata[B_SWRST];
            if (wr) begin
                unique case (idx)
                    IDX_PWR:  r_pwr  <= pwdata[15:0] & MSK_PWR;
                    IDX_CFGA: r_cfga <= pwdata[15:0] & MSK_CFGA; // RQ4
                    IDX_CFGB: r_cfgb <= pwdata[15:0] & MSK_CFGB; // RQ5
                    IDX_JACK: r_jack <= pwdata[15:0] & MSK_JACK;
                    IDX_POP:  r_pop  <= pwdata[15:0] & MSK_POP;
                    default:  ;
                endcase
            end
        end
    end

    // fault latch; a short present on the clearing edge wins
    wire short_det = (hps_s & ~r_cfga[B_SC_DIS]) // RQ4
                   | (vgs_s & ~r_cfga[B_SC_DIS] & ~r_cfgb[B_VG_SC_DIS]) // RQ5
                   | (sps_s & r_cfgb[B_SPK_SC_EN]); // RQ10
    // recovery once the five output drivers are requested off and every flag reports off
    wire recover = &{r_pwr[B_SPK_PD], r_pwr[B_EAR_PD], r_pwr[B_VG_PD],
                     r_pwr[B_HPL_PD], r_pwr[B_HPR_PD]} && (&stat); // RQ3

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault <= 1'b0;
        end else if (short_det) begin
            fault <= 1'b1; // RQ1
        end else if (soft_rst || recover) begin
            fault <= 1'b0; // RQ2
        end
    end

    // driver enables
    assign hs_force = det_en & ~hs_state; // RQ16
    wire hpl_rq = ~r_pwr[B_HPL_PD];
    wire hpr_rq = ~r_pwr[B_HPR_PD];
    wire next_hpl = hpl_rq & ~fault; // RQ1
    wire next_hpr = hpr_rq & ~fault & ~hs_force; // RQ16
    wire next_vg  = ~r_pwr[B_VG_PD] & ~fault & ~hs_force;
    wire next_spk = ~r_pwr[B_SPK_PD] & ~fault;
    // headphones take priority; the earpiece stays off while either is asked for
    wire next_ear = ~r_pwr[B_EAR_PD] & ~fault & ~(hpl_rq | hpr_rq); // RQ11
    wire next_mb  = ~r_pwr[B_MB_PD] & ~fault & ~hs_force;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {hpl, hpr, vg, spk, ear, mb} <= 6'h00;
        end else begin
            {hpl, hpr, vg, spk, ear, mb} <=
                {next_hpl, next_hpr, next_vg, next_spk, next_ear, next_mb};
        end
    end

    assign headphone_left_out   = hpl;
    assign headphone_right_out  = hpr;
    assign virtual_ground_amp   = vg;
    assign loudspeaker_diff_out = spk;
    assign earpiece_diff_out    = ear;
    assign headset_mic_bias     = mb;
    assign route_left_buzzer    = r_pop[B_RT_LEFT]; // RQ12
    assign route_right_buzzer   = r_pop[B_RT_RIGHT]; // RQ12

    // quarter-millisecond base tick and a free running tick count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            qdiv  <= 16'h0000;
            qtick <= 1'b0;
            qcnt  <= 6'h00;
        end else begin
            qtick <= qdiv == 16'(QT_CYC - 1);
            qdiv  <= (qdiv == 16'(QT_CYC - 1)) ? 16'h0000 : qdiv + 16'h0001;
            if (qtick) begin
                qcnt <= qcnt + 6'h01;
            end
        end
    end

    // pop ramp: starts when the first headphone powers up with both off, aborted when both go off
    wire hp_any = hpl | hpr;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hp_prev <= 1'b0;
            pop_cnt <= 14'h0000;
        end else begin
            hp_prev <= hp_any;
            if (!hp_any || r_pop[B_POP_DIS]) begin
                pop_cnt <= 14'h0000; // RQ6
            end else if (!hp_prev) begin // RQ9
                pop_cnt <= vg ? POP_FAST_Q // RQ8
                         : (r_pop[B_RAMP_LNG] ? POP_LONG_Q : POP_SLOW_Q); // RQ7
            end else if (qtick && pop_cnt != 14'h0000) begin
                pop_cnt <= pop_cnt - 14'h0001;
            end
        end
    end
    assign pop_ramp_active = pop_cnt != 14'h0000;

    // headset debounce: tick of 2/4/8/16 ms, eight stable ticks to accept
    wire hs_tick = qtick & tick_at(qcnt, 3'd3 + {1'b0, r_jack[B_HS_DB +: 2]}); // RQ18
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hs_state <= 1'b0;
            hs_cnt   <= 3'h0;
        end else if (!det_en) begin
            hs_state <= 1'b0; // RQ13
            hs_cnt   <= 3'h0;
        end else if (hs_tick) begin
            if (jk_s == hs_state) begin // RQ20
                hs_cnt <= 3'h0; // RQ24
            end else if (hs_cnt == DB_TICKS) begin
                hs_state <= jk_s; // RQ14
                hs_cnt   <= 3'h0;
            end else begin
                hs_cnt <= hs_cnt + 3'h1;
            end
        end
    end

    // insertion or removal pulse, counted in base ticks
    wire hs_chg = det_en && hs_tick && hs_cnt == DB_TICKS && jk_s != hs_state;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hs_pcnt <= 3'h0;
        end else if (hs_chg) begin
            hs_pcnt <= HS_PULSE_Q; // RQ19
        end else if (qtick && hs_pcnt != 3'h0) begin
            hs_pcnt <= hs_pcnt - 3'h1;
        end
    end
    wire hs_irq = hs_pcnt != 3'h0;

    // button debounce: setting 00 passes the pin straight through
    wire [1:0] bt_db  = r_jack[B_BT_DB +: 2];
    wire       bt_raw = (bt_db == 2'b00) ? 1'b1
                        : tick_at(qcnt, 3'd1 + {1'b0, bt_db}); // RQ21
    wire       bt_tick = qtick & bt_raw;
    wire       bt_acc  = (bt_db == 2'b00) ? (bt_s != bt_state)
                        : (bt_tick && bt_s != bt_state && bt_cnt == DB_TICKS);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bt_state <= 1'b0;
            bt_cnt   <= 3'h0;
        end else if (bt_acc) begin
            bt_state <= bt_s; // RQ24
            bt_cnt   <= 3'h0;
        end else if (bt_tick) begin
            bt_cnt <= (bt_s == bt_state) ? 3'h0 : bt_cnt + 3'h1;
        end
    end

    // button interrupt: raised half a millisecond after acceptance,
    // dropped on the first debounce tick after the pin lets go
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bt_wait <= 1'b0;
            bt_dcnt <= 2'h0;
            bt_irq  <= 1'b0;
        end else if (bt_acc && bt_s) begin
            bt_wait <= 1'b1; // RQ22
            bt_dcnt <= BT_DELAY_Q;
        end else if (bt_wait) begin
            if (qtick) begin
                bt_dcnt <= bt_dcnt - 2'h1;
                if (bt_dcnt == 2'h1) begin
                    bt_wait <= 1'b0;
                    bt_irq  <= 1'b1; // RQ22
                end
            end
        end else if (bt_irq && !bt_s && bt_tick) begin
            bt_irq <= 1'b0; // RQ22
        end
    end

    // button flag: press sets it; a read after release clears it, set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bt_flag <= 1'b0;
        end else if (bt_acc && bt_s) begin
            bt_flag <= 1'b1; // RQ17
        end else if (rd_jk && !bt_state) begin
            bt_flag <= 1'b0; // RQ23
        end
    end

    // interrupt pins, active high
    wire bt_en = r_jack[B_BT_INT +: 2] != 2'b00;
    assign gp_pin_one = (hs_irq & r_jack[B_GP1_EN]) | (bt_irq & bt_en); // RQ15 RQ17
    assign gp_pin_two = hs_irq & r_jack[B_GP2_EN]; // RQ15

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_fault_off;
        fault |=> !(hpl || hpr || vg || spk || ear || mb);
    endproperty
    a_fault_off: assert property (p_fault_off) else $error("driver on in fault"); // RQ1

    property p_soft_clear;
        soft_rst && !short_det |=> !fault;
    endproperty
    a_soft_clear: assert property (p_soft_clear) else $error("fault survived reset"); // RQ2

    property p_all_dis;
        r_cfga[B_SC_DIS] && r_cfgb[B_VG_SC_DIS] && !r_cfgb[B_SPK_SC_EN] |=> !$rose(fault);
    endproperty
    a_all_dis: assert property (p_all_dis) else $error("fault while disabled"); // RQ4

    property p_spk_sc;
        sps_s && r_cfgb[B_SPK_SC_EN] |=> fault ##1 !spk;
    endproperty
    a_spk_sc: assert property (p_spk_sc) else $error("speaker short ignored"); // RQ10

    property p_excl;
        !(ear && (hpl || hpr));
    endproperty
    a_excl: assert property (p_excl) else $error("earpiece with headphones"); // RQ11

    property p_force;
        hs_force |=> !hpr && !vg && !mb;
    endproperty
    a_force: assert property (p_force) else $error("forced driver on"); // RQ16

    property p_pop_start;
        $rose(hp_any) && !r_pop[B_POP_DIS] |=> pop_ramp_active;
    endproperty
    a_pop_start: assert property (p_pop_start) else $error("no pop ramp"); // RQ9

    property p_hs_pulse;
        hs_chg |=> hs_pcnt == 3'h7 && (gp_pin_two == r_jack[B_GP2_EN]);
    endproperty
    a_hs_pulse: assert property (p_hs_pulse) else $error("bad headset pulse"); // RQ19

    property p_flag_clr;
        $fell(bt_flag) |-> $past(rd_jk) && !$past(bt_state);
    endproperty
    a_flag_clr: assert property (p_flag_clr) else $error("button flag cleared early"); // RQ23

    c_fault:  cover property ($rose(fault));
    c_insert: cover property ($rose(hs_state));
    c_button: cover property ($rose(bt_irq));
    c_ramp:   cover property ($fell(pop_ramp_active) && hp_any);
endmodule

// >>> sim/hdog_jack_model.sv
module hdog_jack_model (
    // requests from the bench
    input  wire logic       pclk,
    input  wire logic       plug,
    input  wire logic       press,
    input  wire logic [2:0] shorts,
    input  wire logic [3:0] bounce,
    // pins toward the block
    output logic            jack_sense_input,
    output logic            button_sense,
    output logic [2:0]      short_pins
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt    = 4'h0;
    logic       plug_q = 1'b0;
    logic       jack_q = 1'b0;
    logic       btn_q  = 1'b0;
    logic [2:0] sc_q   = 3'h0;
    assign jack_sense_input = jack_q;
    assign button_sense     = btn_q;
    assign short_pins       = sc_q;
    // a moving plug chatters for a while; the block must ride through it
    always_ff @(posedge pclk) begin
        plug_q <= plug;
        if (plug != plug_q) begin
            cnt <= bounce;
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end
        jack_q <= (cnt != 4'h0) ? ~jack_q : plug_q;
        btn_q  <= press;
        sc_q   <= shorts;
    end
endmodule

// >>> sim/headset_detect_output_guard_tb.sv
module headset_detect_output_guard_tb
    import hdog_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int QT = 4;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [9:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic        plug, press, gp1, gp2, hpl, hpr, vg, spk, ear, mb, ramp, rl, rr;
    logic        jack, btn;
    logic [2:0]  shorts, spins;
    logic [3:0]  bounce;
    logic [15:0] rd, v, jv;
    int          n_mismatch = 0;
    int          checks = 0;
    int          cyc = 0;
    int          n, t, f;

    hdog_guard #(.QT_CYC(QT)) hdog_guard_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .jack_sense_input(jack), .button_sense(btn), .hp_short(spins[0]),
        .virtual_ground_amp_short(spins[1]), .spk_short(spins[2]), .headphone_left_out(hpl),
        .headphone_right_out(hpr), .virtual_ground_amp(vg), .loudspeaker_diff_out(spk),
        .earpiece_diff_out(ear), .headset_mic_bias(mb), .pop_ramp_active(ramp),
        .route_left_buzzer(rl), .route_right_buzzer(rr), .gp_pin_one(gp1), .gp_pin_two(gp2)
    );
    hdog_jack_model hdog_jack_model_i (
        .pclk(pclk), .plug(plug), .press(press), .shorts(shorts), .bounce(bounce),
        .jack_sense_input(jack), .button_sense(btn), .short_pins(spins)
    );

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // a hang ends the run as a failure
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 60000) begin
            n_mismatch++;
            conclude();
        end
    end

    task automatic conclude;
        if (n_mismatch == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk16(input string what, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic chk1(input string what, input logic e, input logic g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %b seen %b", what, e, g);
        end
    endtask
    task automatic chkw(input string what, input int g, input int lo, input int hi);
        checks++;
        if (g < lo || g > hi) begin
            n_mismatch++;
            $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, g);
        end
    endtask
    task automatic apb(input logic [7:0] idx, input logic wr, input logic [15:0] wd);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {16'h0000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 64);
        if (k >= 64) begin
            n_mismatch++;
            conclude();
        end
        rd = prdata[15:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic pin(input int w);
        return (w == 0) ? gp1 : (w == 1) ? gp2 : ramp;
    endfunction
    // counts settled cycles until the watched output reaches lvl
    task automatic wpin(input int w, input logic lvl, input int lim);
        n = 0;
        while (pin(w) !== lvl && n < lim) begin
            @(posedge pclk);
            #1;
            n++;
        end
    endtask
    task automatic zap(input logic [2:0] s);
        @(posedge pclk);
        shorts <= s;
        repeat (3) @(posedge pclk);
        shorts <= 3'h0;
        repeat (8) @(posedge pclk);
    endtask
    function automatic logic [15:0] exp_pop(input logic [15:0] p, input logic [15:0] w);
        return {p[B_HPL_PD], p[B_HPR_PD], p[B_VG_PD], p[B_SPK_PD], p[B_EAR_PD], p[B_MB_PD],
                10'h000} | (w & MSK_POP);
    endfunction
    function automatic int hs_tick(input int s);
        return (8 << s) * QT;
    endfunction
    function automatic int bt_tick(input int s);
        return (s == 0) ? 0 : (2 << s) * QT;
    endfunction

    initial begin
        {psel, penable, pwrite, paddr, pwdata, plug, press, shorts, bounce} = '0;
        presetn = 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        void'($urandom(32'h6801dee9));
        apb(IDX_PWR, 0, 0);
        chk16("power", RST_PWR, rd);
        apb(IDX_POP, 0, 0);
        chk16("pop", exp_pop(RST_PWR, 0), rd);
        apb(8'h3F, 0, 0);
        chk1("slverr", 1'b1, err);
        chk16("unmapped", RST_ZERO, rd);
        for (int i = 0; i < 4; i++) begin
            v = 16'($urandom);
            apb(IDX_POP, 1, v);
            apb(IDX_POP, 0, 0);
            chk16("routing", exp_pop(RST_PWR, v), rd);
            chk1("left_buzzer", v[B_RT_LEFT], rl);
            chk1("right_buzzer", v[B_RT_RIGHT], rr);
        end
        apb(IDX_POP, 1, 0);
        apb(IDX_PWR, 1, 16'h1AC0);
        apb(IDX_PWR, 1, 16'h1A40);
        wpin(2, 1, 20);
        wpin(2, 0, 100);
        chkw("fast_ramp", n, (POP_FAST_Q - 1) * QT, POP_FAST_Q * QT + 2);
        apb(IDX_PWR, 1, RST_PWR);
        apb(IDX_POP, 1, 16'h0020);
        apb(IDX_PWR, 1, 16'h1B40);
        wpin(2, 1, 40);
        chkw("no_ramp", n, 40, 40);
        apb(IDX_PWR, 1, RST_PWR);
        apb(IDX_POP, 1, 0);
        apb(IDX_PWR, 1, 16'h1B40);
        wpin(2, 1, 20);
        wpin(2, 0, 14000);
        chkw("slow_ramp", n, (POP_SLOW_Q - 1) * QT, POP_SLOW_Q * QT + 2);
        apb(IDX_PWR, 1, RST_PWR);
        apb(IDX_POP, 1, 16'h0010);
        apb(IDX_PWR, 1, 16'h1B40);
        // the long ramp must outlast the short one
        repeat (POP_SLOW_Q * QT + 40) @(posedge pclk);
        chk1("long_ramp", 1'b1, ramp);
        apb(IDX_PWR, 1, 16'h1340);
        repeat (4) @(posedge pclk);
        chk1("earpiece", 1'b0, ear);
        chk1("hp_left", 1'b1, hpl);
        zap(3'b001);
        chk1("hp_left", 1'b0, hpl);
        apb(IDX_FAULT, 0, 0);
        chk16("fault", 16'h0002, rd);
        apb(IDX_FAULT, 1, 16'h8000);
        apb(IDX_FAULT, 0, 0);
        chk16("fault", RST_ZERO, rd);
        apb(IDX_PWR, 0, 0);
        chk16("power", RST_PWR, rd);
        apb(IDX_POP, 1, 16'h0020);
        apb(IDX_PWR, 1, 16'h1B40);
        zap(3'b001);
        // host side of recovery: all drivers down, then wait for every status flag
        apb(IDX_PWR, 1, RST_PWR);
        f = 0;
        do begin
            apb(IDX_POP, 0, 0);
            f++;
        end while (rd[15:10] !== 6'h3F && f < 20);
        apb(IDX_FAULT, 0, 0);
        chk16("fault", RST_ZERO, rd);
        apb(IDX_PWR, 1, 16'h1B40);
        apb(IDX_CFGA, 1, 16'h0001);
        zap(3'b001);
        chk1("hp_left", 1'b1, hpl);
        apb(IDX_CFGA, 1, 16'h0000);
        apb(IDX_CFGB, 1, 16'h0010);
        zap(3'b010);
        apb(IDX_FAULT, 0, 0);
        chk16("fault", RST_ZERO, rd);
        apb(IDX_CFGB, 1, 16'h0020);
        apb(IDX_PWR, 1, 16'h0B40);
        zap(3'b100);
        apb(IDX_FAULT, 0, 0);
        chk16("fault", 16'h0002, rd);
        chk1("speaker", 1'b0, spk);
        apb(IDX_FAULT, 1, 16'h8000);
        apb(IDX_POP, 1, 16'h0020);
        apb(IDX_PWR, 1, 16'h0800);
        plug <= 1'b1;
        wpin(1, 1, 400);
        apb(IDX_JACK, 0, 0);
        chk16("jack", RST_ZERO, rd);
        plug <= 1'b0;
        repeat (400) @(posedge pclk);
        f = $urandom % 4;
        t = hs_tick(f);
        jv = 16'h8018 | 16'(f << B_HS_DB);
        apb(IDX_JACK, 1, jv);
        repeat (4) @(posedge pclk);
        chk1("hp_right", 1'b0, hpr);
        chk1("virtual_ground_amp", 1'b0, vg);
        chk1("mic_bias", 1'b0, mb);
        bounce <= 4'($urandom % 8);
        plug <= 1'b1;
        wpin(1, 1, 9 * t + 64);
        chkw("insert_delay", n, 7 * t, 9 * t + 24);
        chk1("gp_one", 1'b1, gp1);
        wpin(1, 0, 60);
        chkw("insert_pulse", n, (HS_PULSE_Q - 1) * QT, HS_PULSE_Q * QT + 2);
        apb(IDX_JACK, 0, 0);
        chk16("jack", jv | 16'h1000, rd);
        chk1("hp_right", 1'b1, hpr);
        f = $urandom % 4;
        t = bt_tick(f);
        v = jv & 16'hFFE7 | 16'h0011 | 16'(f << B_BT_DB);
        apb(IDX_JACK, 1, v);
        press <= 1'b1;
        wpin(0, 1, 9 * t + 64);
        chkw("button_delay", n, 7 * t, 9 * t + 3 * QT + 6);
        apb(IDX_JACK, 0, 0);
        chk16("jack", v | 16'h1800, rd);
        repeat (20) @(posedge pclk);
        apb(IDX_JACK, 0, 0);
        chk16("jack", v | 16'h1800, rd);
        press <= 1'b0;
        wpin(0, 0, t + 64);
        chkw("button_hold", n, 1, t + 2 * QT + 6);
        // let the debounced release settle before the clearing read
        repeat (8 * t + 8) @(posedge pclk);
        apb(IDX_JACK, 0, 0);
        chk16("jack", v | 16'h1800, rd);
        apb(IDX_JACK, 0, 0);
        chk16("jack", v | 16'h1000, rd);
        plug <= 1'b0;
        wpin(1, 1, 2400);
        wpin(1, 0, 60);
        apb(IDX_JACK, 0, 0);
        chk16("jack", v, rd);
        chk1("hp_right", 1'b0, hpr);
        conclude();
    end
endmodule
